// ### design/mpt_defs.vh
// register offsets, field positions, encodings and reset values of the period timer core
`ifndef MPT_DEFS_VH
`define MPT_DEFS_VH

// ==========================================================
// register byte offsets
`define MPT_OFF_CTRL      12'h000
`define MPT_OFF_COUNT     12'h004
`define MPT_OFF_PERIOD    12'h008
`define MPT_OFF_STATUS    12'h00c

// ==========================================================
// control register fields
`define MPT_CTRL_CLR_BIT  2
`define MPT_CTRL_MODE_LO  4
`define MPT_CTRL_MODE_HI  5
`define MPT_CTRL_DIV_LO   6
`define MPT_CTRL_DIV_HI   7
`define MPT_CTRL_SRC_LO   8
`define MPT_CTRL_SRC_HI   9
`define MPT_CTRL_LEN_LO   11
`define MPT_CTRL_LEN_HI   12

// ==========================================================
// status register fields
`define MPT_STAT_OVF_BIT  0
`define MPT_STAT_CMP_BIT  1
`define MPT_STAT_DIR_BIT  2

// ==========================================================
// mode control encodings
`define MPT_MODE_STOP     2'h0
`define MPT_MODE_UP       2'h1
`define MPT_MODE_CONT     2'h2
`define MPT_MODE_UPDN     2'h3

// ==========================================================
// length select encodings and maximum counts
`define MPT_LEN_8         2'h0
`define MPT_LEN_10        2'h1
`define MPT_LEN_12        2'h2
`define MPT_LEN_16        2'h3
`define MPT_MAX_8         16'h00ff
`define MPT_MAX_10        16'h03ff
`define MPT_MAX_12        16'h0fff
`define MPT_MAX_16        16'hffff

// ==========================================================
// clock source encodings
`define MPT_SRC_AUX       2'h0
`define MPT_SRC_SUBSYS    2'h1
`define MPT_SRC_EXT       2'h2
`define MPT_SRC_ALT_EXT   2'h3

// ==========================================================
// reset values
`define MPT_RST_CTRL      16'h0000
`define MPT_RST_COUNT     16'h0000
`define MPT_RST_PERIOD    16'h0000
`define MPT_RST_DIV       3'h0

`endif

// ### design/mpt_timer_core.v
// counter core of the multimode period timer with its apb register slave
`timescale 1ns/1ps
`include "mpt_defs.vh"

module mpt_timer_core
(
	// clock and reset
	input  wire        i_clk,
	input  wire        i_arst_n,
	// apb slave
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output wire        o_pready,
	output wire        o_pslverr,
	output wire [31:0] o_prdata,
	// timer clock sources, asynchronous pins
	input  wire        i_aux_clk,
	input  wire        i_subsys_clk,
	input  wire        i_ext_clk,
	input  wire        i_alt_ext_clk,
	// counter state
	output wire [15:0] o_count,
	output wire        o_overflow_flag,
	output wire        o_compare_match_flag
);

	// ==========================================================
	// helper functions

	// maximum count of a length select code
	function [15:0] len_max;
		input [1:0] len;
		begin
			if (len == `MPT_LEN_8)
				len_max = `MPT_MAX_8;
			else if (len == `MPT_LEN_10)
				len_max = `MPT_MAX_10;
			else if (len == `MPT_LEN_12)
				len_max = `MPT_MAX_12;
			else
				len_max = `MPT_MAX_16;
		end
	endfunction

	// divide ratio minus one for the divider select code
	function [2:0] div_last;
		input [1:0] sel;
		begin
			div_last = (3'h1 << sel) - 3'h1;
		end
	endfunction

	// ==========================================================
	// state

	reg  [1:0]  mode_r;
	reg  [1:0]  div_sel_r;
	reg  [1:0]  src_sel_r;
	reg  [1:0]  len_sel_r;
	reg  [15:0] count_r;
	reg  [15:0] count_nxt;
	reg  [15:0] period_r;
	reg         dir_down_r;
	reg         dir_down_nxt;
	reg         ovf_r;
	reg         cmp_r;
	reg         ovf_set;
	reg         cmp_set;
	reg  [2:0]  div_cnt_r;
	reg  [3:0]  src_pin_s1_r;
	reg  [3:0]  src_pin_s2_r;
	reg  [3:0]  src_pin_s3_r;
	reg  [3:0]  src_lvl_r;
	reg  [31:0] prdata_r;
	reg         slverr_r;

	wire        wr_acc;
	wire        rd_setup;
	wire        hit_ctrl;
	wire        hit_count;
	wire        hit_period;
	wire        hit_status;
	wire        mapped;
	wire        clr_req;
	wire        src_edge;
	wire        tick;
	wire [15:0] max_cnt;
	wire [15:0] wdata16;

	// ==========================================================
	// apb decode

	// zero wait states: read data is latched in the setup cycle
	assign wr_acc     = i_psel & i_penable & i_pwrite;
	assign rd_setup   = i_psel & ~i_penable & ~i_pwrite;
	assign hit_ctrl   = (i_paddr == `MPT_OFF_CTRL);
	assign hit_count  = (i_paddr == `MPT_OFF_COUNT);
	assign hit_period = (i_paddr == `MPT_OFF_PERIOD);
	assign hit_status = (i_paddr == `MPT_OFF_STATUS);
	assign mapped     = hit_ctrl | hit_count | hit_period | hit_status;
	assign clr_req    = wr_acc & hit_ctrl & i_pwdata[`MPT_CTRL_CLR_BIT];
	assign wdata16    = i_pwdata[15:0];
	assign max_cnt    = len_max(len_sel_r);

	assign o_pready   = i_psel & i_penable;
	assign o_pslverr  = slverr_r & i_psel & i_penable;
	assign o_prdata   = prdata_r;

	// read data and error answer, captured when the address first appears
	always @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			prdata_r <= 32'h0000_0000;
			slverr_r <= 1'b0;
		end
		else if (i_psel & ~i_penable)
		begin
			slverr_r <= ~mapped;
			if (!rd_setup)
				prdata_r <= 32'h0000_0000;
			else if (hit_ctrl)
				prdata_r <= {19'h0, len_sel_r, 1'b0, src_sel_r, div_sel_r, mode_r, 4'h0};
			else if (hit_count)
				prdata_r <= {16'h0, count_r};
			else if (hit_period)
				prdata_r <= {16'h0, period_r};
			else if (hit_status)
				prdata_r <= {29'h0, dir_down_r, cmp_r, ovf_r};
			else
				prdata_r <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// control register

	// the clear bit is a strobe and always reads back as zero
	always @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			mode_r    <= `MPT_MODE_STOP;
			div_sel_r <= 2'h0;
			src_sel_r <= 2'h0;
			len_sel_r <= 2'h0;
		end
		else if (wr_acc & hit_ctrl)
		begin
			mode_r    <= i_pwdata[`MPT_CTRL_MODE_HI:`MPT_CTRL_MODE_LO];
			div_sel_r <= i_pwdata[`MPT_CTRL_DIV_HI:`MPT_CTRL_DIV_LO];
			src_sel_r <= i_pwdata[`MPT_CTRL_SRC_HI:`MPT_CTRL_SRC_LO];
			len_sel_r <= i_pwdata[`MPT_CTRL_LEN_HI:`MPT_CTRL_LEN_LO];
		end
	end

	// ==========================================================
	// clock source synchronisers

	// three stages per pin; only stages two and three feed the edge detector
	// a level change counts once stages two and three agree, so a one-sample glitch never ticks
	always @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			src_pin_s1_r <= 4'h0;
			src_pin_s2_r <= 4'h0;
			src_pin_s3_r <= 4'h0;
			src_lvl_r    <= 4'h0;
		end
		else
		begin
			src_pin_s1_r <= {i_alt_ext_clk, i_ext_clk, i_subsys_clk, i_aux_clk};
			src_pin_s2_r <= src_pin_s1_r;
			src_pin_s3_r <= src_pin_s2_r;
			src_lvl_r    <= (src_pin_s2_r & src_pin_s3_r) | (src_lvl_r & (src_pin_s2_r | src_pin_s3_r));
		end
	end

	// select after synchronising so a source switch never glitches a stage
	assign src_edge = src_pin_s2_r[src_sel_r] & src_pin_s3_r[src_sel_r] & ~src_lvl_r[src_sel_r];

	// ==========================================================
	// input divider

	// a stopped source gives no edges, so the counter simply waits
	always @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			div_cnt_r <= `MPT_RST_DIV;
		else if (clr_req)
			div_cnt_r <= `MPT_RST_DIV;
		else if (src_edge)
		begin
			if (div_cnt_r >= div_last(div_sel_r))
				div_cnt_r <= 3'h0;
			else
				div_cnt_r <= div_cnt_r + 3'h1;
		end
	end

	assign tick = src_edge & (div_cnt_r >= div_last(div_sel_r)) & (mode_r != `MPT_MODE_STOP);

	// ==========================================================
	// counter next state

	// flags only rise from tick-driven transitions, never from a write
	always @*
	begin
		count_nxt    = count_r;
		dir_down_nxt = dir_down_r;
		ovf_set      = 1'b0;
		cmp_set      = 1'b0;
		if (tick)
		begin
			if (mode_r == `MPT_MODE_CONT || (mode_r == `MPT_MODE_UPDN && period_r > max_cnt))
			begin
				if (count_r >= max_cnt)
				begin
					count_nxt = 16'h0000;
					ovf_set   = 1'b1;
				end
				else
					count_nxt = count_r + 16'h0001;
				cmp_set = (count_nxt == period_r);
			end
			else if (period_r == 16'h0000)
				count_nxt = count_r;
			else if (mode_r == `MPT_MODE_UP)
			begin
				if (count_r == period_r)
				begin
					count_nxt = 16'h0000;
					ovf_set   = 1'b1;
				end
				else if (count_r > period_r)
					count_nxt = 16'h0000;
				else
				begin
					count_nxt = count_r + 16'h0001;
					cmp_set   = (count_nxt == period_r);
				end
			end
			else
			begin
				// up/down, period within the length
				if (dir_down_r)
				begin
					if (count_r == 16'h0000)
					begin
						dir_down_nxt = 1'b0;
						count_nxt    = 16'h0001;
						cmp_set      = (period_r == 16'h0001);
					end
					else
					begin
						count_nxt = count_r - 16'h0001;
						ovf_set   = (count_r == 16'h0001);
						if (count_r == 16'h0001)
							dir_down_nxt = 1'b0;
					end
				end
				else if (count_r >= period_r)
				begin
					dir_down_nxt = 1'b1;
					count_nxt    = count_r - 16'h0001;
					ovf_set      = (count_r == 16'h0001);
					if (count_r == 16'h0001)
						dir_down_nxt = 1'b0;
				end
				else
				begin
					count_nxt = count_r + 16'h0001;
					cmp_set   = (count_nxt == period_r);
				end
			end
			count_nxt = count_nxt & max_cnt;
		end
	end

	// ==========================================================
	// count, direction and period registers

	// software writes win over a tick in the same cycle
	always @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			count_r    <= `MPT_RST_COUNT;
			dir_down_r <= 1'b0;
		end
		else if (clr_req)
		begin
			count_r    <= 16'h0000;
			dir_down_r <= 1'b0;
		end
		else if (wr_acc & hit_count)
			count_r <= wdata16 & max_cnt;
		else if (wr_acc & hit_period & (period_r == 16'h0000) & (wdata16 != 16'h0000) &
			(mode_r == `MPT_MODE_UP || mode_r == `MPT_MODE_UPDN))
		begin
			count_r    <= 16'h0000;
			dir_down_r <= 1'b0;
		end
		else
		begin
			count_r    <= count_nxt & max_cnt;
			dir_down_r <= dir_down_nxt;
		end
	end

	// period latch loads immediately on write
	always @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			period_r <= `MPT_RST_PERIOD;
		else if (wr_acc & hit_period)
			period_r <= wdata16;
	end

	// ==========================================================
	// event flags

	// write one to clear; a set in the same cycle wins
	always @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			ovf_r <= 1'b0;
			cmp_r <= 1'b0;
		end
		else
		begin
			if (ovf_set)
				ovf_r <= 1'b1;
			else if (wr_acc & hit_status & i_pwdata[`MPT_STAT_OVF_BIT])
				ovf_r <= 1'b0;
			if (cmp_set)
				cmp_r <= 1'b1;
			else if (wr_acc & hit_status & i_pwdata[`MPT_STAT_CMP_BIT])
				cmp_r <= 1'b0;
		end
	end

	assign o_count              = count_r;
	assign o_overflow_flag      = ovf_r;
	assign o_compare_match_flag = cmp_r;

endmodule // mpt_timer_core

// ### dv/mpt_timer_core_props.sv
// concurrent checks on the ports of the period timer core
`timescale 1ns/1ps
module mpt_timer_core_props
(
	// apb side
	input logic        i_clk, i_arst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr,
	input logic [11:0] i_paddr,
	input logic [31:0] i_pwdata, o_prdata,
	// timer sources and counter state
	input logic        i_aux_clk, i_subsys_clk, i_ext_clk, i_alt_ext_clk, o_overflow_flag, o_compare_match_flag,
	input logic [15:0] o_count
);
	// ==========================================================
	// shadow of written mode, length and period
	logic [1:0]  mode_r, len_r;
	logic [15:0] per_r, msk_w, wdat_w;
	logic        wr_w;
	assign wr_w = i_psel & i_penable & i_pwrite;
	assign wdat_w = i_pwdata[15:0];
	// mask of the selected length; bits above it must read zero
	assign msk_w = len_r == 2'h0 ? 16'h00ff : len_r == 2'h1 ? 16'h03ff : len_r == 2'h2 ? 16'h0fff : 16'hffff;
	// taken at the same edge as the core takes the write
	always_ff @(posedge i_clk or negedge i_arst_n)
		if (!i_arst_n)
		begin
			mode_r <= 2'h0;
			len_r <= 2'h0;
			per_r <= 16'h0000;
		end
		else if (wr_w && i_paddr == 12'h000)
		begin
			mode_r <= i_pwdata[5:4];
			len_r <= i_pwdata[12:11];
		end
		else if (wr_w && i_paddr == 12'h008)
			per_r <= wdat_w;

	// ==========================================================
	// properties
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);
	rdy_access_a: assert property (i_psel && i_penable |-> o_pready)
		else $error("pready low in access phase");
	cnt_write_a: assert property (wr_w && i_paddr == 12'h004 |=> o_count == (msk_w & $past(wdat_w)))
		else $error("count write not taken at once");
	stop_hold_a: assert property (mode_r == 2'h0 && !wr_w |=> $stable(o_count))
		else $error("count moved while stopped");
	len_zero_a: assert property (!$past(wr_w) |-> (o_count & ~msk_w) == 16'h0000)
		else $error("count bits above length set");
	cont_step_a: assert property (mode_r == 2'h2 && !$past(wr_w) && $changed(o_count) |->
		o_count == $past(o_count) + 16'h0001 || o_count == 16'h0000)
		else $error("continuous count skipped a value");
	ovf_zero_a: assert property ($rose(o_overflow_flag) |-> o_count == 16'h0000)
		else $error("overflow flag set away from zero");
	cmp_period_a: assert property ($rose(o_compare_match_flag) |-> o_count == per_r)
		else $error("compare flag set away from period");
	write_quiet_a: assert property (wr_w && i_paddr == 12'h004 && !o_overflow_flag |=> !o_overflow_flag)
		else $error("count write raised overflow flag");
	// main scenarios reached
	ovf_seen_c: cover property ($rose(o_overflow_flag));
	cmp_seen_c: cover property ($rose(o_compare_match_flag));
	err_seen_c: cover property (i_psel && i_penable && o_pslverr);
endmodule // mpt_timer_core_props

bind mpt_timer_core mpt_timer_core_props u_props (.*);

// ### dv/tb_mpt_timer_core.sv
// self-checking bench for the period timer core over apb
`timescale 1ns/1ps
`include "mpt_defs.vh"
module tb_mpt_timer_core;
	// ==========================================================
	// core ports and bench state
	logic        i_clk = '0, i_arst_n = '0, i_psel = '0, i_penable = '0, i_pwrite = '0, rerr;
	logic [11:0] i_paddr = '0;
	logic [31:0] i_pwdata = '0, rdat;
	logic [3:0]  tsrc = '0;
	wire         i_aux_clk = tsrc[0], i_subsys_clk = tsrc[1], i_ext_clk = tsrc[2], i_alt_ext_clk = tsrc[3];
	wire         o_pready, o_pslverr, o_overflow_flag, o_compare_match_flag;
	wire [31:0]  o_prdata;
	wire [15:0]  o_count;
	wire [31:0]  cnt = {16'h0, o_count};
	wire [31:0]  flg = {30'h0, o_overflow_flag, o_compare_match_flag};
	int          error_cnt = 0, n_tests = 0, cyc = 0, cur = 0;
	logic [15:0] mx [4] = '{`MPT_MAX_8, `MPT_MAX_10, `MPT_MAX_12, `MPT_MAX_16};

	mpt_timer_core u_dut (.*);

	// ==========================================================
	// clock and hang guard
	initial
		forever
			#50 i_clk = ~i_clk;
	// a run needs about 730 cycles; far beyond that it hangs
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			wrap_up();
		end
	end

	// ==========================================================
	// tasks
	task automatic wrap_up;
		if (error_cnt == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s: exp %h seen %h", n, e, g);
		end
	endtask
	// one transfer; idle cycle after it so psel is never driven twice at one edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		// only the bench timeout ends a wait for pready
		do
		begin
			@(posedge i_clk);
		end
		while (o_pready !== 1'b1);
		rdat = o_prdata;
		rerr = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, '0);
		chk(n, e, rdat);
	endtask
	// source pulses of 4 cycles high and 4 low, slow enough for the synchroniser
	task automatic tick(input int n);
		repeat (n)
		begin
			tsrc[cur] <= 1'b1;
			repeat (4) @(posedge i_clk);
			tsrc[cur] <= 1'b0;
			repeat (4) @(posedge i_clk);
		end
	endtask
	function automatic logic [31:0] cfg(input logic [1:0] m, d, s, l);
		return {19'h0, l, 1'b0, s, d, m, 4'h0};
	endfunction

	// ==========================================================
	// main sequence
	initial
	begin
		repeat (8) @(posedge i_clk);
		i_arst_n <= 1'b1;
		repeat (4) @(posedge i_clk);
		rc("ctrl reset", `MPT_OFF_CTRL, '0);
		rc("count reset", `MPT_OFF_COUNT, '0);
		apb(1'b0, 12'h010, 32'hffff_ffff);
		chk("unmapped error", 32'h1, {31'h0, rerr});
		chk("unmapped data", '0, rdat);
		// continuous wrap at each length; period zero acts only as a compare value
		for (int l = 0; l < 4; l++)
		begin
			wr(`MPT_OFF_CTRL, cfg(2'h2, 2'h0, 2'h0, l[1:0]));
			wr(`MPT_OFF_COUNT, 32'hffff);
			rc("masked count", `MPT_OFF_COUNT, {16'h0, mx[l]});
			rc("flags after write", `MPT_OFF_STATUS, '0);
			tick(1);
			chk("wrap count", '0, cnt);
			rc("wrap flags", `MPT_OFF_STATUS, 32'h3);
			wr(`MPT_OFF_STATUS, 32'h3);
		end
		// each source with its own divider; clear restarts the prescaler
		for (int s = 0; s < 4; s++)
		begin
			wr(`MPT_OFF_CTRL, cfg(2'h2, s[1:0], s[1:0], 2'h3) | 32'h4);
			cur = s;
			tick(2 << s);
			chk("divided count", 32'h2, cnt);
		end
		cur = 0;
		// up mode, 16-bit length: 32'h1800 stops, 32'h1810 runs up
		wr(`MPT_OFF_CTRL, 32'h1804);
		wr(`MPT_OFF_STATUS, 32'h3);
		wr(`MPT_OFF_PERIOD, 32'h3);
		wr(`MPT_OFF_CTRL, 32'h1810);
		tick(3);
		chk("up top", 32'h3, cnt);
		chk("up top flags", 32'h1, flg);
		tick(1);
		chk("up roll", '0, cnt);
		chk("up roll flags", 32'h3, flg);
		wr(`MPT_OFF_CTRL, 32'h1800);
		wr(`MPT_OFF_COUNT, 32'ha);
		wr(`MPT_OFF_CTRL, 32'h1810);
		tick(1);
		chk("up restart", '0, cnt);
		tick(2);
		wr(`MPT_OFF_PERIOD, 32'h1);
		tick(1);
		chk("up shrink", '0, cnt);
		tick(1);
		wr(`MPT_OFF_PERIOD, '0);
		tick(2);
		chk("zero period halt", 32'h1, cnt);
		wr(`MPT_OFF_PERIOD, 32'h5);
		tick(2);
		chk("restart from zero", 32'h2, cnt);
		// up/down, 16-bit length: 32'h1830 runs
		wr(`MPT_OFF_CTRL, 32'h1804);
		wr(`MPT_OFF_STATUS, 32'h3);
		wr(`MPT_OFF_PERIOD, 32'h2);
		wr(`MPT_OFF_CTRL, 32'h1830);
		tick(2);
		chk("top flags", 32'h1, flg);
		tick(2);
		chk("down to zero", '0, cnt);
		chk("bottom flags", 32'h3, flg);
		tick(3);
		rc("down direction", `MPT_OFF_STATUS, 32'h7);
		wr(`MPT_OFF_CTRL, 32'h1800);
		tick(1);
		chk("stopped", 32'h1, cnt);
		wr(`MPT_OFF_CTRL, 32'h1830);
		tick(1);
		chk("resume down", '0, cnt);
		tick(3);
		wr(`MPT_OFF_CTRL, 32'h1834);
		chk("clear count", '0, cnt);
		rc("clear direction", `MPT_OFF_STATUS, 32'h3);
		tick(3);
		wr(`MPT_OFF_PERIOD, 32'h4);
		tick(1);
		chk("descent kept", '0, cnt);
		tick(3);
		chk("new period climb", 32'h3, cnt);
		wr(`MPT_OFF_PERIOD, 32'h2);
		tick(1);
		chk("shrink turns down", 32'h2, cnt);
		// 8-bit length, period beyond its maximum
		wr(`MPT_OFF_CTRL, 32'h4);
		wr(`MPT_OFF_PERIOD, 32'h1ff);
		wr(`MPT_OFF_COUNT, 32'hfe);
		wr(`MPT_OFF_CTRL, 32'h30);
		tick(2);
		chk("long period wraps", '0, cnt);
		wrap_up();
	end
endmodule // tb_mpt_timer_core
